/* design/pmw_pkg.sv */
// Functional notes
// R1 - A rising one-hertz alarm flag raises an RTC wake request, even from deep power-down
// R2 - Leaving deep power-down restarts all registers and core state from reset values; the code keeps wake_cause and sets from_dpd
// R3 - All functional pins are high impedance during deep power-down
// R4 - Deep power-down turns everything off except the RTC and its oscillator
// R5 - The comparator may run in deep-sleep but never wakes the device; the code lets an enabled, clocked comparator interrupt end sleep
// R6 - Only the primary watchdog interrupt wakes from deep-sleep
// R7 - Only the primary watchdog drives a full chip reset
// R8 - In sleep, any enabled interrupt from a clocked peripheral resumes the processor
// R9 - Hardware activity wake works in sleep, and per enable bit in deep-sleep
// R10 - Deep-sleep accepts 1 Hz alarm, pin, OS timer, micro-tick and converter wakes
// R11 - A USART port wakes from deep-sleep only in slave or low-frequency clock mode
// R12 - SPI, I2C, I2S ports and I3C wake from deep-sleep only in slave mode
// R13 - The USB need-clock interrupt is a deep-sleep wake source
// R14 - Software enables each wake interrupt; a disabled interrupt never wakes; the code ends deep power-down on an RTC alarm whatever irq_en holds
// R15 - A deep-sleep wake source needs its start-enable bit set in either word
// R16 - The DSP wakes the main processor through the message unit interrupt
// R17 - The micro-tick timer stays usable as a deep-sleep wake source
// R18 - Sleep stops the processor clock until a reset or an interrupt
// R19 - Deep-sleep stops main and peripheral clocks except those kept for waking
// R20 - Wake requests are synchronised before gating, so glitches cannot wake
// R21 - The reset pin leaves any reduced power mode with no enable needed
package pmw_pkg;
    localparam int         SRC_N          = 16;
    localparam int         START_W        = 8;
    localparam int         PK_W           = 11;
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_START_LOW  = 8'h04;
    localparam logic [7:0] OFS_START_HIGH = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN     = 8'h0c;
    localparam logic [7:0] OFS_CLK_KEEP   = 8'h10;
    localparam logic [7:0] OFS_PWR_KEEP   = 8'h14;
    localparam logic [7:0] OFS_HW_WAKE_EN = 8'h18;
    localparam logic [7:0] OFS_STATUS     = 8'h1c;
    // Field positions
    localparam int         CTRL_MODE_LSB  = 0;
    localparam int         CTRL_GO        = 4;
    localparam int         PK_OSC_LSB     = 0;
    localparam int         PK_PLL_LSB     = 4;
    localparam int         PK_SRAM_ARR    = 6;
    localparam int         PK_SRAM_PER    = 7;
    localparam int         PK_ADC         = 8;
    localparam int         PK_CMP         = 9;
    localparam int         PK_RTC_OSC     = 10;
    localparam int         STAT_FROM_DPD  = 3;
    localparam int         STAT_CAUSE_LSB = 16;
    // Reset values
    localparam logic [START_W-1:0] START_RESET    = 8'h00;
    localparam logic [SRC_N-1:0]   IRQ_EN_RESET   = 16'h0000;
    localparam logic [SRC_N-1:0]   CLK_KEEP_RESET = 16'h0000;
    localparam logic [SRC_N-1:0]   HW_EN_RESET    = 16'h0000;
    localparam logic [PK_W-1:0]    PWR_KEEP_RESET = 11'h400;
    // Wake source slots; low start word gates 0..7, high word 8..15
    localparam int SRC_PIN_INT      = 0;
    localparam int SRC_WDT_PRIMARY  = 1;
    localparam int SRC_WDT_OTHER    = 2;
    localparam int SRC_RTC_1HZ      = 3;
    localparam int SRC_RTC_ALARM    = 4;
    localparam int SRC_UTICK        = 5;
    localparam int SRC_OS_TIMER     = 6;
    localparam int SRC_SERIAL       = 7;
    localparam int SRC_I3C          = 8;
    localparam int SRC_USB_NEED_CLK = 9;
    localparam int SRC_DMA          = 10;
    localparam int SRC_DIGITAL_MIC  = 11;
    localparam int SRC_HW_WAKE      = 12;
    localparam int SRC_ADC          = 13;
    localparam int SRC_COMPARATOR   = 14;
    localparam int SRC_MSG_UNIT     = 15;
    // Sources allowed to end deep-sleep: all but comparator and other watchdogs
    localparam logic [SRC_N-1:0] DS_ALLOWED = 16'hbffb;

    typedef enum logic [1:0]
    {
        MODE_NONE  = 2'h0,
        MODE_SLEEP = 2'h1,
        MODE_DEEP  = 2'h2,
        MODE_DPD   = 2'h3
    } mode_type;

    typedef enum logic [2:0]
    {
        ST_ACTIVE  = 3'h0,
        ST_SLEEP   = 3'h1,
        ST_DEEP    = 3'h3,
        ST_DPD     = 3'h2,
        ST_RESTORE = 3'h6
    } state_type;
endpackage : pmw_pkg

/* design/power_mode_wake_control.sv */
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module power_mode_wake_control
    import pmw_pkg::*;
#(
    parameter int SER_N = 8
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [7:0]       paddr,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [SRC_N-1:0] periph_irq,
    input  wire logic [SER_N-1:0] serial_irq,
    input  wire logic [SER_N-1:0] serial_slave,
    input  wire logic [SER_N-1:0] serial_usart,
    input  wire logic [SER_N-1:0] serial_lowfreq,
    input  wire logic             i3c_slave,
    input  wire logic [SER_N:0]   hardware_activity_wake,
    input  wire logic             one_hertz_alarm_flag,
    input  wire logic             primary_watchdog_reset,
    input  wire logic             reset_pin_n,
    output logic                  cpu_clk_run,
    output logic                  main_clk_run,
    output logic      [SRC_N-1:0] periph_clk_run,
    output logic      [3:0]       osc_run,
    output logic      [1:0]       pll_run,
    output logic                  sram_array_on,
    output logic                  sram_periph_on,
    output logic                  adc_on,
    output logic                  cmp_on,
    output logic                  rtc_osc_run,
    output logic                  pin_hiz,
    output logic                  core_domain_reset,
    output logic                  cpu_wake,
    output logic                  rtc_wake_irq,
    output logic                  chip_reset_req
);
    localparam int SYNC_W = SRC_N + 2 * SER_N + 3;

    if (SER_N < 1 || SER_N + 1 > SRC_N)
    begin : g_bad_ser
        $error("SER_N must lie between 1 and 15");
    end

    state_type            state;
    state_type            next_state;
    logic [START_W-1:0]   start_enable_word_low;
    logic [START_W-1:0]   start_enable_word_high;
    logic [SRC_N-1:0]     irq_en;
    logic [SRC_N-1:0]     clk_keep;
    logic [PK_W-1:0]      pwr_keep;
    logic [SRC_N-1:0]     hw_wake_en;
    logic [SRC_N-1:0]     wake_cause;
    logic                 from_dpd;
    logic                 alarm_q;
    logic [SRC_N-1:0]     s_periph;
    logic [SER_N-1:0]     s_serial;
    logic [SER_N:0]       s_hw;
    logic                 alarm_s;
    logic                 reset_hit;
    logic                 alarm_rise;
    logic                 ser_ok;
    logic [SRC_N-1:0]     sleep_hits;
    logic [SRC_N-1:0]     deep_hits;
    logic                 dpd_wake;
    logic                 apb_setup;
    logic                 apb_wr;
    logic                 go_req;
    logic                 dpd_exit;
    logic [31:0]          rd_val;
    logic                 rd_hit;

    wake_sync_if #(.W(SYNC_W)) sync_bus ();

    // Every asynchronous request passes the synchroniser before any gating
    assign sync_bus.raw = {~reset_pin_n, one_hertz_alarm_flag, hardware_activity_wake,
                           serial_irq, periph_irq}; // [R20]

    wake_sync #(.W(SYNC_W)) u_sync
    (
        .clk (clk),
        .rst (rst),
        .bus (sync_bus)
    );

    assign s_periph  = sync_bus.synced[SRC_N-1:0];
    assign s_serial  = sync_bus.synced[SRC_N+SER_N-1:SRC_N];
    assign s_hw      = sync_bus.synced[SRC_N+2*SER_N:SRC_N+SER_N];
    assign alarm_s   = sync_bus.synced[SYNC_W-2];
    assign reset_hit = sync_bus.synced[SYNC_W-1];

    serial_wake_qual #(.N(SER_N)) u_qual
    (
        .irq     (s_serial),
        .slave   (serial_slave),
        .usart   (serial_usart),
        .lowfreq (serial_lowfreq),
        .any_ok  (ser_ok)
    );

    // Alarm edge, taken from the synchronised copy only
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            alarm_q <= 1'b0;
        else
            alarm_q <= alarm_s;
    end

    assign alarm_rise = alarm_s & ~alarm_q; // [R1]

    // Sleep: any enabled interrupt of a clocked peripheral, plus activity wake
    always_comb
    begin
        sleep_hits = s_periph;
        sleep_hits[SRC_RTC_1HZ] = alarm_rise;
        sleep_hits[SRC_SERIAL] = |s_serial;
        sleep_hits[SRC_HW_WAKE] = 1'b0;
        sleep_hits = sleep_hits & irq_en & clk_keep; // [R8] [R14]
        sleep_hits[SRC_HW_WAKE] = |s_hw; // [R9]
    end

    // Deep-sleep: role-qualified serial ports, start words, fixed allow mask
    always_comb
    begin
        deep_hits = s_periph; // [R10] [R13] [R16] [R17]
        deep_hits[SRC_RTC_1HZ] = alarm_rise; // [R10]
        deep_hits[SRC_SERIAL] = ser_ok; // [R11] [R12]
        deep_hits[SRC_I3C] = s_periph[SRC_I3C] & i3c_slave; // [R12]
        deep_hits[SRC_HW_WAKE] = |(s_hw & hw_wake_en[SER_N:0]); // [R9]
        deep_hits = deep_hits & irq_en; // [R14]
        deep_hits = deep_hits & {start_enable_word_high, start_enable_word_low}; // [R15]
        deep_hits = deep_hits & DS_ALLOWED; // [R5] [R6]
    end

    // Deep power-down keeps only the RTC and the reset pin alive
    assign dpd_wake = alarm_rise | s_periph[SRC_RTC_ALARM] | reset_hit; // [R1] [R21]

    assign apb_setup = psel & ~penable;
    assign apb_wr    = psel & penable & pready & pwrite;
    assign go_req    = apb_wr && paddr == OFS_CTRL && pwdata[CTRL_GO]
                       && pwdata[CTRL_MODE_LSB+1:CTRL_MODE_LSB] != MODE_NONE;
    assign dpd_exit  = state == ST_DPD && next_state == ST_RESTORE;

    // Mode sequencing; the reset pin needs no enable to end any mode
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_ACTIVE:
            begin
                if (go_req)
                begin
                    unique case (mode_type'(pwdata[CTRL_MODE_LSB+1:CTRL_MODE_LSB]))
                        MODE_SLEEP: next_state = ST_SLEEP;
                        MODE_DEEP:  next_state = ST_DEEP;
                        MODE_DPD:   next_state = ST_DPD;
                        MODE_NONE:  next_state = ST_ACTIVE;
                    endcase
                end
            end
            ST_SLEEP:
                if (|sleep_hits || reset_hit)
                    next_state = ST_RESTORE; // [R18] [R21]
            ST_DEEP:
                if (|deep_hits || reset_hit)
                    next_state = ST_RESTORE; // [R21]
            ST_DPD:
                if (dpd_wake)
                    next_state = ST_RESTORE;
            ST_RESTORE:
                next_state = ST_ACTIVE;
            default:
                next_state = ST_ACTIVE;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state <= ST_ACTIVE;
        else
            state <= next_state;
    end

    // Configuration words; a power-down exit throws them all away
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            start_enable_word_low  <= START_RESET;
            start_enable_word_high <= START_RESET;
            irq_en                 <= IRQ_EN_RESET;
            clk_keep               <= CLK_KEEP_RESET;
            pwr_keep               <= PWR_KEEP_RESET;
            hw_wake_en             <= HW_EN_RESET;
        end
        else if (dpd_exit)
        begin
            start_enable_word_low  <= START_RESET; // [R2]
            start_enable_word_high <= START_RESET;
            irq_en                 <= IRQ_EN_RESET;
            clk_keep               <= CLK_KEEP_RESET;
            pwr_keep               <= PWR_KEEP_RESET;
            hw_wake_en             <= HW_EN_RESET;
        end
        else if (apb_wr)
        begin
            unique case (paddr)
                OFS_START_LOW:  start_enable_word_low  <= pwdata[START_W-1:0];
                OFS_START_HIGH: start_enable_word_high <= pwdata[START_W-1:0];
                OFS_IRQ_EN:     irq_en                 <= pwdata[SRC_N-1:0];
                OFS_CLK_KEEP:   clk_keep               <= pwdata[SRC_N-1:0];
                OFS_PWR_KEEP:   pwr_keep               <= pwdata[PK_W-1:0];
                OFS_HW_WAKE_EN: hw_wake_en             <= pwdata[SRC_N-1:0];
                default:        ;
            endcase
        end
    end

    // Wake bookkeeping seen by software after the restore
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wake_cause <= '0;
            from_dpd   <= 1'b0;
        end
        else if (next_state == ST_RESTORE)
        begin
            wake_cause <= (state == ST_SLEEP) ? sleep_hits : deep_hits;
            from_dpd   <= state == ST_DPD;
        end
    end

    // Read mux; the status word is read-only
    always_comb
    begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (paddr)
            OFS_CTRL:       rd_val = 32'h0000_0000;
            OFS_START_LOW:  rd_val[START_W-1:0] = start_enable_word_low;
            OFS_START_HIGH: rd_val[START_W-1:0] = start_enable_word_high;
            OFS_IRQ_EN:     rd_val[SRC_N-1:0] = irq_en;
            OFS_CLK_KEEP:   rd_val[SRC_N-1:0] = clk_keep;
            OFS_PWR_KEEP:   rd_val[PK_W-1:0] = pwr_keep;
            OFS_HW_WAKE_EN: rd_val[SRC_N-1:0] = hw_wake_en;
            OFS_STATUS:
            begin
                rd_val[2:0] = state;
                rd_val[STAT_FROM_DPD] = from_dpd;
                rd_val[STAT_CAUSE_LSB+SRC_N-1:STAT_CAUSE_LSB] = wake_cause;
            end
            default:        rd_hit = 1'b0;
        endcase
    end

    // Zero wait states: answer is ready in the first access cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~rd_hit;
            if (apb_setup && !pwrite)
                prdata <= rd_val;
        end
    end

    // Clock gating follows the state being entered, so outputs match it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cpu_clk_run    <= 1'b1;
            main_clk_run   <= 1'b1;
            periph_clk_run <= '1;
        end
        else
        begin
            cpu_clk_run  <= next_state == ST_ACTIVE || next_state == ST_RESTORE; // [R18]
            main_clk_run <= next_state != ST_DEEP && next_state != ST_DPD; // [R19]
            unique case (next_state)
                ST_SLEEP, ST_DEEP: periph_clk_run <= clk_keep; // [R19]
                ST_DPD:            periph_clk_run <= '0; // [R4]
                default:           periph_clk_run <= '1;
            endcase
        end
    end

    // Analog and memory power; only the RTC oscillator survives power-down
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            osc_run        <= 4'hf;
            pll_run        <= 2'h3;
            sram_array_on  <= 1'b1;
            sram_periph_on <= 1'b1;
            adc_on         <= 1'b1;
            cmp_on         <= 1'b1;
            rtc_osc_run    <= 1'b1;
        end
        else
        begin
            rtc_osc_run <= pwr_keep[PK_RTC_OSC]; // [R4]
            unique case (next_state)
                ST_SLEEP, ST_DEEP:
                begin
                    osc_run        <= pwr_keep[PK_OSC_LSB+3:PK_OSC_LSB];
                    pll_run        <= pwr_keep[PK_PLL_LSB+1:PK_PLL_LSB];
                    sram_array_on  <= pwr_keep[PK_SRAM_ARR];
                    sram_periph_on <= pwr_keep[PK_SRAM_PER];
                    adc_on         <= pwr_keep[PK_ADC];
                    cmp_on         <= pwr_keep[PK_CMP]; // [R5]
                end
                ST_DPD:
                begin
                    osc_run        <= 4'h0; // [R4]
                    pll_run        <= 2'h0;
                    sram_array_on  <= 1'b0;
                    sram_periph_on <= 1'b0;
                    adc_on         <= 1'b0;
                    cmp_on         <= 1'b0;
                end
                default:
                begin
                    osc_run        <= 4'hf;
                    pll_run        <= 2'h3;
                    sram_array_on  <= 1'b1;
                    sram_periph_on <= 1'b1;
                    adc_on         <= 1'b1;
                    cmp_on         <= 1'b1;
                end
            endcase
        end
    end

    // Pins, core reset and wake pulses
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin_hiz           <= 1'b0;
            core_domain_reset <= 1'b0;
            cpu_wake          <= 1'b0;
            rtc_wake_irq      <= 1'b0;
            chip_reset_req    <= 1'b0;
        end
        else
        begin
            pin_hiz           <= next_state == ST_DPD; // [R3]
            core_domain_reset <= next_state == ST_DPD || dpd_exit; // [R2]
            cpu_wake          <= next_state == ST_RESTORE;
            rtc_wake_irq      <= alarm_rise; // [R1]
            chip_reset_req    <= primary_watchdog_reset; // [R7]
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_dpd_pins_float: assert property (state == ST_DPD |-> pin_hiz) // [R3]
        else $error("pins not floating in power-down");
    a_dpd_all_off: assert property (state == ST_DPD |-> osc_run == 4'h0 && pll_run == 2'h0
        && !sram_array_on && !adc_on && !cmp_on && periph_clk_run == '0) // [R4]
        else $error("block left powered in power-down");
    a_dpd_exit_reset: assert property (dpd_exit |=> core_domain_reset
        && irq_en == IRQ_EN_RESET && state == ST_RESTORE) // [R2]
        else $error("power-down exit kept old state");
    a_alarm_wake_irq: assert property ($rose(alarm_s) |=> rtc_wake_irq ##1 !rtc_wake_irq) // [R1]
        else $error("alarm edge gave no wake request");
    a_ds_bad_sources: assert property (state == ST_DEEP
        |-> !deep_hits[SRC_COMPARATOR] && !deep_hits[SRC_WDT_OTHER]) // [R5] [R6]
        else $error("forbidden deep-sleep wake source");
    a_ds_start_gate: assert property (state == ST_DEEP && !reset_hit
        && (deep_hits == '0) |=> state == ST_DEEP) // [R15]
        else $error("deep-sleep left without enabled source");
    a_sleep_resume: assert property (state == ST_SLEEP && |sleep_hits
        |=> state == ST_RESTORE ##1 state == ST_ACTIVE && cpu_clk_run) // [R8]
        else $error("sleep wake did not resume processor");
    a_sleep_cpu_stop: assert property (state == ST_SLEEP |-> !cpu_clk_run) // [R18]
        else $error("processor clock running in sleep");
    a_reset_pin_wake: assert property ((state == ST_SLEEP || state == ST_DEEP
        || state == ST_DPD) && reset_hit |=> state == ST_RESTORE) // [R21]
        else $error("reset pin did not end low power mode");
    a_deep_clocks: assert property (state == ST_DEEP
        |-> !main_clk_run && periph_clk_run == clk_keep) // [R19]
        else $error("deep-sleep clocks not gated");
    a_wdt_chip_reset: assert property (primary_watchdog_reset |=> chip_reset_req) // [R7]
        else $error("watchdog reset not forwarded");

    c_sleep_cycle: cover property (state == ST_SLEEP ##[1:50] state == ST_ACTIVE);
    c_deep_wake: cover property (state == ST_DEEP && |deep_hits);
    c_dpd_exit: cover property (dpd_exit ##1 core_domain_reset);
endmodule : power_mode_wake_control

/* design/serial_wake_qual.sv */
`timescale 1ns/10ps
module serial_wake_qual #(parameter int N = 8)
(
    input wire logic [N-1:0] irq,
    input wire logic [N-1:0] slave,
    input wire logic [N-1:0] usart,
    input wire logic [N-1:0] lowfreq,
    output logic             any_ok
);
    if (N < 1)
    begin : g_bad_n
        $error("serial_wake_qual needs at least one port");
    end

    // Slave role qualifies every port; a USART may also run from the slow clock
    assign any_ok = |(irq & (slave | (usart & lowfreq))); // [R11] [R12]
endmodule : serial_wake_qual

/* design/wake_sync.sv */
`timescale 1ns/10ps
module wake_sync #(parameter int W = 1)
(
    input wire logic   clk,
    input wire logic   rst,
    wake_sync_if.syncer bus
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;

    if (W < 1)
    begin : g_bad_width
        $error("wake_sync width must be at least one");
    end

    // Two flops per bit; the first is read only by the second
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stage1 <= '0;
            stage2 <= '0;
        end
        else
        begin
            stage1 <= bus.raw;
            stage2 <= stage1;
        end
    end

    assign bus.synced = stage2;
endmodule : wake_sync

/* design/wake_sync_if.sv */
`timescale 1ns/10ps
interface wake_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport owner  (output raw, input synced);
    modport syncer (input raw, output synced);
endinterface : wake_sync_if

/* testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
    import pmw_pkg::*;
    typedef struct packed {logic [4:0] src; logic [3:0] ser; logic [15:0] st; logic exp;} row_type;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, fire = 0, ack = 0, i3c_slave = 0;
    logic one_hertz_alarm_flag = 0, primary_watchdog_reset = 0, reset_pin_n = 1;
    logic [7:0] paddr = '0, serial_irq = '0, serial_slave = '0, serial_usart = '0;
    logic [7:0] serial_lowfreq = '0;
    logic [8:0] hardware_activity_wake = '0;
    logic [3:0] slot = '0, osc_run;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [15:0] periph_irq, periph_clk_run;
    logic [1:0] pll_run;
    logic pready, pslverr, lerr, cpu_clk_run, main_clk_run, sram_array_on, sram_periph_on, adc_on;
    logic cmp_on, rtc_osc_run, pin_hiz, core_domain_reset, cpu_wake, rtc_wake_irq, chip_reset_req;
    logic sw, sr;
    int err_total = 0, n_checks = 0, cyc = 0;
    row_type r;
    // Deep-sleep cases: source slot (16 = serial port), serial bits, start words, wake expected
    row_type rows [13] = '{'{0,0,16'h0001,1}, '{0,0,16'h0000,0}, '{14,0,16'h4000,0},
        '{2,0,16'h0004,0}, '{1,0,16'h0002,1}, '{5,0,16'h0020,1}, '{9,0,16'h0200,1},
        '{15,0,16'h8000,1}, '{13,0,16'h2000,1}, '{16,4'hc,16'h0080,1}, '{16,4'ha,16'h0080,0},
        '{16,4'hb,16'h0080,1}, '{8,0,16'h0100,0}};

    power_mode_wake_control i_power_mode_wake_control (.*);
    wake_partner i_wake_partner (.*);

    always #12.5 clk = ~clk;
    // Cut a hang short; the whole run needs a few hundred cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        lerr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    // Pulses are one cycle wide, so sample every cycle
    task watch(input int n);
        sw = 0;
        sr = 0;
        repeat (n)
        begin
            @(negedge clk);
            sw |= cpu_wake;
            sr |= rtc_wake_irq;
        end
    endtask : watch

    task tally_and_finish;
        if (err_total == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 0;
        apb(0, OFS_PWR_KEEP, 0);
        check(rd, 32'h400);
        apb(0, 8'h40, 0);
        check(lerr, 1);
        foreach (rows[i])
        begin
            r = rows[i];
            apb(1, OFS_IRQ_EN, 32'hffff);
            apb(1, OFS_START_LOW, r.st[7:0]);
            apb(1, OFS_START_HIGH, r.st[15:8]);
            serial_slave[0] <= r.ser[2];
            serial_usart[0] <= r.ser[1];
            serial_lowfreq[0] <= r.ser[0];
            apb(1, OFS_CTRL, 32'h12);
            fire <= !r.src[4];
            slot <= r.src[3:0];
            serial_irq[0] <= r.ser[3];
            @(negedge clk);
            check(main_clk_run, 0);
            @(posedge clk);
            fire <= 0;
            watch(8);
            check(sw, r.exp);
            @(posedge clk);
            ack <= 1;
            serial_irq <= 0;
            reset_pin_n <= r.exp;
            watch(6);
            check(cpu_clk_run, 1);
            @(posedge clk);
            ack <= 0;
            reset_pin_n <= 1;
        end
        apb(1, OFS_IRQ_EN, 32'hffff);
        apb(1, OFS_CLK_KEEP, 32'h40);
        apb(1, OFS_CTRL, 32'h11);
        fire <= 1;
        slot <= 6;
        @(negedge clk);
        check(cpu_clk_run, 0);
        check(periph_clk_run[6], 1);
        @(posedge clk);
        fire <= 0;
        watch(8);
        check(sw, 1);
        @(posedge clk);
        ack <= 1;
        apb(1, OFS_CTRL, 32'h11);
        ack <= 0;
        hardware_activity_wake[8] <= 1;
        watch(8);
        check(sw, 1);
        @(posedge clk);
        hardware_activity_wake <= 0;
        primary_watchdog_reset <= 1;
        @(posedge clk);
        primary_watchdog_reset <= 0;
        @(negedge clk);
        check(chip_reset_req, 1);
        apb(1, OFS_IRQ_EN, 32'hffff);
        apb(1, OFS_CTRL, 32'h13);
        one_hertz_alarm_flag <= 1;
        @(negedge clk);
        check(pin_hiz, 1);
        check({osc_run, pll_run, sram_array_on, sram_periph_on, adc_on, cmp_on}, 0);
        check(rtc_osc_run, 1);
        check(core_domain_reset, 1);
        watch(8);
        check(sr, 1);
        check(pin_hiz, 0);
        check(core_domain_reset, 0);
        apb(0, OFS_IRQ_EN, 0);
        check(rd, 0);
        tally_and_finish();
    end
endmodule : testbench

/* testbench/wake_partner.sv */
`timescale 1ns/10ps
module wake_partner
    import pmw_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             fire,
    input  wire logic [3:0]       slot,
    input  wire logic             ack,
    output logic      [SRC_N-1:0] periph_irq
);
    initial periph_irq = '0;
    // Level request held until serviced, as a real interrupt line would
    always @(posedge clk)
    begin
        if (ack)
            periph_irq <= '0;
        else if (fire)
            periph_irq[slot] <= 1'b1;
    end
endmodule : wake_partner
